// *** shared/pxge_pkg.sv ***
// shared constants and types for the proximity config and gesture entry block
// Contract
// (R1) result is read-only 8-bit register
// (R2) up/right pair scaled by its offset
// (R3) down/left pair scaled by its offset
// (R4) offsets decoded sign/magnitude, -127 to +127
// (R5) host writes zero to config bits 7:6
// (R6) compensation bit doubles proximity gain
// (R7) host sets compensation for single-diode patterns
// (R8) sleep after interrupt at decision point
// (R9) wake only when host clears interrupt
// (R10) mask bit set excludes that photodiode
// (R11) result against entry threshold enters gesture
// (R12) entry needs one comparison, no persistence
// (R13) host keeps threshold bit 4 zero
// (R14) reading result clears proximity valid flag
// (R15) pair offsets applied before result stored
package pxge_pkg;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam logic [7:0] OFS_PROXIMITY_RESULT = 8'h9C;
    localparam logic [7:0] OFS_OFFSET_UP_RIGHT = 8'h9D;
    localparam logic [7:0] OFS_OFFSET_DOWN_LEFT = 8'h9E;
    localparam logic [7:0] OFS_PHOTODIODE_SELECT_CONFIG = 8'h9F;
    localparam logic [7:0] OFS_GESTURE_ENTRY_THRESHOLD = 8'hA0;
    localparam logic [7:0] OFS_DEVICE_STATUS = 8'hA8;
    localparam logic [7:0] OFS_CLEAR_INTERRUPT = 8'hE7;
    localparam int CFG_RESERVED_HI = 7;
    localparam int CFG_RESERVED_LO = 6;
    localparam int CFG_PAIR_GAIN_COMP = 5;
    localparam int CFG_SLEEP_AFTER_INTERRUPT = 4;
    localparam int CFG_MASK_UP_DIODE = 3;
    localparam int CFG_MASK_DOWN_DIODE = 2;
    localparam int CFG_MASK_LEFT_DIODE = 1;
    localparam int CFG_MASK_RIGHT_DIODE = 0;
    localparam int THR_RESERVED_BIT = 4;
    localparam int STS_PROXIMITY_VALID = 1;
    localparam int STS_GESTURE_ACTIVE = 2;
    localparam int STS_LOW_POWER = 3;
    localparam int STS_INTERRUPT = 4;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_THRESHOLD = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RESULT_MAX = 8'hFF;
    localparam logic [7:0] APB_OFS_COMMAND = 8'h00;
    localparam logic [7:0] APB_OFS_STATUS = 8'h04;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_WRITE_BIT = 16;
    localparam int HST_BUSY_BIT = 0;
    localparam int HST_INT_BIT = 1;
    localparam int HST_DONE_BIT = 2;
    localparam int HST_RDATA_LSB = 8;
    typedef logic [REG_DW-1:0] pxge_byte_t;
    typedef enum logic [1:0] {PXGE_IDLE, PXGE_REQ, PXGE_DONE} pxge_host_state_t;
endpackage

// *** shared/pxge_if.sv ***
// register link joining the sensing device and its host controller
`timescale 1ns/1ps
interface pxge_if;
    import pxge_pkg::*;
    logic reg_wr;
    logic reg_rd;
    logic [REG_AW-1:0] reg_addr;
    pxge_byte_t reg_wdata;
    pxge_byte_t reg_rdata;
    logic reg_ack;
    logic int_pin;
    modport device (input reg_wr, input reg_rd, input reg_addr, input reg_wdata,
                    output reg_rdata, output reg_ack, output int_pin);
    modport host (output reg_wr, output reg_rd, output reg_addr, output reg_wdata,
                  input reg_rdata, input reg_ack, input int_pin);
endinterface

// *** rtl/pxge_device.sv ***
// proximity result, crosstalk offsets, diode selection and gesture entry
`timescale 1ns/1ps
module pxge_device (
    input wire logic pclk,
    input wire logic presetn,
    pxge_if.device link,
    input wire logic [7:0] diode_up,
    input wire logic [7:0] diode_down,
    input wire logic [7:0] diode_left,
    input wire logic [7:0] diode_right,
    input wire logic sample_strobe,
    input wire logic int_event,
    input wire logic gesture_exit,
    output logic [7:0] proximity_result,
    output logic proximity_valid_flag,
    output logic gesture_active,
    output logic low_power
);
    import pxge_pkg::*;

    pxge_byte_t offset_up_right_r;
    pxge_byte_t offset_down_left_r;
    pxge_byte_t config_r;
    pxge_byte_t threshold_r;
    pxge_byte_t result_r;
    logic valid_r;
    logic gesture_r;
    logic sleep_r;
    logic int_r;
    logic ack_r;
    pxge_byte_t rdata_r;
    logic req;
    logic wr_acc;
    logic rd_acc;
    logic cycle_done;
    logic signed [11:0] pair_ur;
    logic signed [11:0] pair_dl;
    logic signed [11:0] total;
    pxge_byte_t result_nxt;

    // sign/magnitude byte to signed factor; negative zero also gives zero
    function automatic logic signed [11:0] sm_decode(input pxge_byte_t v);
        logic signed [11:0] mag;
        mag = signed'({5'h00, v[6:0]});
        return v[7] ? -mag : mag; // [R4]
    endfunction

    function automatic logic signed [11:0] pick(input logic masked, input pxge_byte_t d);
        return masked ? 12'sh000 : signed'({4'h0, d}); // [R10]
    endfunction

    assign req = (link.reg_wr | link.reg_rd) & ~ack_r;
    assign wr_acc = req & link.reg_wr;
    assign rd_acc = req & link.reg_rd & ~link.reg_wr;
    // sleeping device takes no new samples
    assign cycle_done = sample_strobe & ~sleep_r;

    // pairs are summed then corrected, so the stored result is compensated
    always_comb begin
        pair_ur = pick(config_r[CFG_MASK_UP_DIODE], diode_up)
                + pick(config_r[CFG_MASK_RIGHT_DIODE], diode_right)
                - sm_decode(offset_up_right_r); // [R2] [R15]
        pair_dl = pick(config_r[CFG_MASK_DOWN_DIODE], diode_down)
                + pick(config_r[CFG_MASK_LEFT_DIODE], diode_left)
                - sm_decode(offset_down_left_r); // [R3] [R15]
        total = pair_ur + pair_dl;
        if (config_r[CFG_PAIR_GAIN_COMP]) begin
            total = total <<< 1; // [R6]
        end
        if (total < 12'sh000) begin
            result_nxt = RST_RESULT;
        end else if (total > signed'({4'h0, RESULT_MAX})) begin
            result_nxt = RESULT_MAX;
        end else begin
            result_nxt = total[7:0];
        end
    end

    // control registers; reserved config bits are kept as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_up_right_r <= RST_OFFSET;
            offset_down_left_r <= RST_OFFSET;
            config_r <= RST_CONFIG;
            threshold_r <= RST_THRESHOLD;
        end else if (wr_acc) begin
            unique case (link.reg_addr)
                OFS_OFFSET_UP_RIGHT: offset_up_right_r <= link.reg_wdata; // [R2]
                OFS_OFFSET_DOWN_LEFT: offset_down_left_r <= link.reg_wdata; // [R3]
                OFS_PHOTODIODE_SELECT_CONFIG: config_r <= link.reg_wdata;
                OFS_GESTURE_ENTRY_THRESHOLD: threshold_r <= link.reg_wdata;
                default: ;
            endcase
        end
    end

    // result is never written by the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= RST_RESULT;
        end else if (cycle_done) begin
            result_r <= result_nxt; // [R1]
        end
    end

    // a completing cycle in the same clock as the read keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r <= 1'b0;
        end else if (cycle_done) begin
            valid_r <= 1'b1;
        end else if (rd_acc && link.reg_addr == OFS_PROXIMITY_RESULT) begin
            valid_r <= 1'b0; // [R14]
        end
    end

    // single comparison enters; no persistence count in the path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gesture_r <= 1'b0;
        end else if (cycle_done && result_nxt >= threshold_r) begin
            gesture_r <= 1'b1; // [R11] [R12]
        end else if (gesture_exit) begin
            gesture_r <= 1'b0;
        end
    end

    // interrupt line: event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_r <= 1'b0;
        end else if (int_event) begin
            int_r <= 1'b1;
        end else if (wr_acc && link.reg_addr == OFS_CLEAR_INTERRUPT) begin
            int_r <= 1'b0; // [R9]
        end
    end

    // decision point is the end of a proximity cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_r <= 1'b0;
        end else if (sleep_r) begin
            if (!int_r) begin
                sleep_r <= 1'b0; // [R9]
            end
        end else if (cycle_done && int_r && config_r[CFG_SLEEP_AFTER_INTERRUPT]) begin
            sleep_r <= 1'b1; // [R8]
        end
    end

    // one-cycle answer, then ack low for a cycle before the next request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= req;
            if (rd_acc) begin
                unique case (link.reg_addr)
                    OFS_PROXIMITY_RESULT: rdata_r <= result_r; // [R1]
                    OFS_OFFSET_UP_RIGHT: rdata_r <= offset_up_right_r;
                    OFS_OFFSET_DOWN_LEFT: rdata_r <= offset_down_left_r;
                    OFS_PHOTODIODE_SELECT_CONFIG: rdata_r <= config_r;
                    OFS_GESTURE_ENTRY_THRESHOLD: rdata_r <= threshold_r;
                    OFS_DEVICE_STATUS: begin
                        rdata_r <= 8'h00;
                        rdata_r[STS_PROXIMITY_VALID] <= valid_r;
                        rdata_r[STS_GESTURE_ACTIVE] <= gesture_r;
                        rdata_r[STS_LOW_POWER] <= sleep_r;
                        rdata_r[STS_INTERRUPT] <= int_r;
                    end
                    default: rdata_r <= 8'h00;
                endcase
            end
        end
    end

    assign link.reg_ack = ack_r;
    assign link.reg_rdata = rdata_r;
    assign link.int_pin = int_r;
    assign proximity_result = result_r;
    assign proximity_valid_flag = valid_r;
    assign gesture_active = gesture_r;
    assign low_power = sleep_r;
endmodule

// *** rtl/pxge_host.sv ***
// host controller: apb command and status registers driving the register link
`timescale 1ns/1ps
module pxge_host (
    input wire logic pclk,
    input wire logic presetn,
    pxge_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import pxge_pkg::*;

    pxge_host_state_t state_r;
    logic [REG_AW-1:0] addr_r;
    pxge_byte_t wdata_r;
    logic write_r;
    pxge_byte_t rdata_r;
    logic done_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic access;
    logic cmd_go;
    pxge_byte_t wdata_clean;

    assign access = psel & penable & ~pready_r;
    // command lands on the completing edge, where the master samples pready
    assign cmd_go = psel & penable & pready_r & pwrite & (paddr == APB_OFS_COMMAND)
                  & (state_r == PXGE_IDLE);

    // reserved bits are forced to zero so software slips cannot set them
    always_comb begin
        wdata_clean = pwdata[CMD_DATA_LSB +: REG_DW];
        if (pwdata[CMD_ADDR_LSB +: REG_AW] == OFS_PHOTODIODE_SELECT_CONFIG) begin
            wdata_clean[CFG_RESERVED_HI:CFG_RESERVED_LO] = 2'b00; // [R5]
        end
        if (pwdata[CMD_ADDR_LSB +: REG_AW] == OFS_GESTURE_ENTRY_THRESHOLD) begin
            wdata_clean[THR_RESERVED_BIT] = 1'b0; // [R13]
        end
    end

    // apb slave answers on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= access;
            pslverr_r <= access & (paddr != APB_OFS_COMMAND) & (paddr != APB_OFS_STATUS);
            if (access && !pwrite) begin
                prdata_r <= 32'h0000_0000;
                if (paddr == APB_OFS_STATUS) begin
                    prdata_r[HST_BUSY_BIT] <= (state_r != PXGE_IDLE);
                    prdata_r[HST_INT_BIT] <= link.int_pin;
                    prdata_r[HST_DONE_BIT] <= done_r;
                    prdata_r[HST_RDATA_LSB +: REG_DW] <= rdata_r;
                end
            end
        end
    end

    // request held until acknowledged; a busy write is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PXGE_IDLE;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            write_r <= 1'b0;
            rdata_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            unique case (state_r)
                PXGE_IDLE: begin
                    if (cmd_go) begin
                        addr_r <= pwdata[CMD_ADDR_LSB +: REG_AW];
                        wdata_r <= wdata_clean;
                        write_r <= pwdata[CMD_WRITE_BIT];
                        done_r <= 1'b0;
                        state_r <= PXGE_REQ;
                    end
                end
                PXGE_REQ: begin
                    if (link.reg_ack) begin
                        if (!write_r) begin
                            rdata_r <= link.reg_rdata;
                        end
                        state_r <= PXGE_DONE;
                    end
                end
                PXGE_DONE: begin
                    done_r <= 1'b1;
                    state_r <= PXGE_IDLE;
                end
            endcase
        end
    end

    // the clear-interrupt write is the only path out of device sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= link.int_pin; // [R9]
        end
    end

    assign link.reg_wr = (state_r == PXGE_REQ) & write_r;
    assign link.reg_rd = (state_r == PXGE_REQ) & ~write_r;
    assign link.reg_addr = addr_r;
    assign link.reg_wdata = wdata_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
endmodule

// *** test/pxge_link_asserts.sv ***
// link checker between the host controller and the sensing device
`timescale 1ns/1ps
module pxge_link_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pxge_pkg::REG_AW-1:0] reg_addr,
    input wire pxge_pkg::pxge_byte_t reg_wdata,
    input wire pxge_pkg::pxge_byte_t reg_rdata,
    input wire logic reg_ack,
    input wire logic int_pin
);
    import pxge_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic req;
    assign req = reg_wr | reg_rd;
    sequence req_taken;
        req && !reg_ack;
    endsequence
    // holes in the map, only the status address excluded; the clear address is included
    sequence unmapped_read;
        reg_rd && !reg_wr && !reg_ack && (reg_addr < OFS_PROXIMITY_RESULT ||
            (reg_addr > OFS_GESTURE_ENTRY_THRESHOLD && reg_addr != OFS_DEVICE_STATUS));
    endsequence
    ack_latency_a: assert property (req_taken |=> reg_ack)
        else $error("link ack late");
    ack_pulse_a: assert property (reg_ack |=> !reg_ack)
        else $error("link ack too long");
    ack_cause_a: assert property (reg_ack |-> $past(req))
        else $error("link ack without request");
    req_hold_a: assert property (req_taken |=> req && $stable(reg_addr) && $stable(reg_wdata))
        else $error("link request changed before ack");
    req_release_a: assert property (reg_ack |=> !req)
        else $error("link request not released");
    cfg_reserved_a: assert property (
        reg_wr && reg_addr == OFS_PHOTODIODE_SELECT_CONFIG
        |-> reg_wdata[CFG_RESERVED_HI:CFG_RESERVED_LO] == 2'b00)
        else $error("config reserved bits written high");
    thr_reserved_a: assert property (
        reg_wr && reg_addr == OFS_GESTURE_ENTRY_THRESHOLD |-> !reg_wdata[THR_RESERVED_BIT])
        else $error("threshold bit 4 written high");
    unmapped_zero_a: assert property (unmapped_read |=> reg_ack && reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    int_seen_c: cover property ($rose(int_pin));
endmodule

// *** test/tb_top.sv ***
// self-checking bench joining the host controller and the sensing device
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import pxge_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, m, e;
    logic pready, pslverr, irq, err, chk_on = 1'b0;
    logic [7:0] diode_up = 8'h00, diode_down = 8'h00, diode_left = 8'h00, diode_right = 8'h00;
    logic sample_strobe = 1'b0, int_event = 1'b0, gesture_exit = 1'b0;
    logic [7:0] proximity_result, ou, od, cf, th;
    logic proximity_valid_flag, gesture_active, low_power;
    int fail_count = 0, checks_done = 0, cycles = 0, t, ex;
    integer seed = 32'h0E499340;
    logic [31:0] exp_q[$], mask_q[$];
    always #25 pclk = ~pclk;
    pxge_if link();
    pxge_device i_pxge_device(.pclk(pclk), .presetn(presetn), .link(link),
        .diode_up(diode_up), .diode_down(diode_down), .diode_left(diode_left),
        .diode_right(diode_right), .sample_strobe(sample_strobe), .int_event(int_event),
        .gesture_exit(gesture_exit), .proximity_result(proximity_result),
        .proximity_valid_flag(proximity_valid_flag), .gesture_active(gesture_active),
        .low_power(low_power));
    pxge_host i_pxge_host(.pclk(pclk), .presetn(presetn), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    pxge_link_asserts i_pxge_link_asserts(.pclk(pclk), .presetn(presetn),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
        .int_pin(link.int_pin));
    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // only reads flagged by the driver carry a note
    always @(posedge pclk) begin
        if (chk_on && psel && penable && pready === 1'b1 && mask_q.size() > 0) begin
            m = mask_q.pop_front();
            e = exp_q.pop_front();
            `CHK(prdata & m, e)
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic c, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        chk_on <= c;
        @(posedge pclk);
        penable <= 1'b1;
        // pready high ends this wait; it has no timeout of its own, only the bench one
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_on <= 1'b0;
    endtask
    task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [31:0] s;
        apb(1'b1, APB_OFS_COMMAND, {15'h0, w, d, a}, 1'b0, s);
        do begin
            apb(1'b0, APB_OFS_STATUS, 32'h0, 1'b0, s);
        end while (s[HST_BUSY_BIT] !== 1'b0 || s[HST_DONE_BIT] !== 1'b1);
    endtask
    task automatic note(input logic [31:0] mk, input logic [31:0] ev);
        logic [31:0] s;
        mask_q.push_back(mk);
        exp_q.push_back(ev);
        apb(1'b0, APB_OFS_STATUS, 32'h0, 1'b1, s);
    endtask
    task automatic rd_dev(input logic [7:0] a, input logic [7:0] ev);
        cmd(1'b0, a, 8'h00);
        note(32'h0000FF00, {16'h0, ev, 8'h00});
    endtask
    task automatic strobe();
        @(posedge pclk);
        sample_strobe <= 1'b1;
        @(posedge pclk);
        sample_strobe <= 1'b0;
        repeat (2) @(negedge pclk);
    endtask
    function automatic int sm(input logic [7:0] v);
        return v[7] ? -int'(v[6:0]) : int'(v[6:0]);
    endfunction
    // one diode left, or only up+left or only right+down, cuts the signal, so software asks for gain
    function automatic logic comp_needed(input logic [3:0] mk);
        return mk inside {4'h7, 4'hB, 4'hD, 4'hE, 4'h5, 4'hA};
    endfunction
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd_dev(OFS_PROXIMITY_RESULT + 8'(i), 8'h00);
        cmd(1'b1, OFS_PHOTODIODE_SELECT_CONFIG, 8'hFF);
        rd_dev(OFS_PHOTODIODE_SELECT_CONFIG, 8'h3F);
        cmd(1'b1, OFS_GESTURE_ENTRY_THRESHOLD, 8'hFF);
        rd_dev(OFS_GESTURE_ENTRY_THRESHOLD, 8'hEF);
        rd_dev(8'h50, 8'h00);
        apb(1'b0, 8'h10, 32'h0, 1'b0, e);
        `CHK(err, 1'b1)
        for (int i = 0; i < 14; i++) begin
            ou = 8'($random(seed));
            od = (i == 0) ? 8'h80 : 8'($random(seed));
            cf = 8'($random(seed)) & 8'h0F;
            cf[CFG_PAIR_GAIN_COMP] = comp_needed(cf[3:0]);
            th = 8'($random(seed)) & 8'hEF;
            cmd(1'b1, OFS_OFFSET_UP_RIGHT, ou);
            cmd(1'b1, OFS_OFFSET_DOWN_LEFT, od);
            cmd(1'b1, OFS_PHOTODIODE_SELECT_CONFIG, cf);
            cmd(1'b1, OFS_GESTURE_ENTRY_THRESHOLD, th);
            rd_dev(OFS_OFFSET_UP_RIGHT, ou);
            @(posedge pclk);
            diode_up <= 8'($random(seed)) >> (i % 4);
            diode_down <= 8'($random(seed)) >> (i % 3);
            diode_left <= 8'($random(seed)) >> (i % 4);
            diode_right <= 8'($random(seed)) >> (i % 3);
            gesture_exit <= 1'b1;
            @(posedge pclk);
            gesture_exit <= 1'b0;
            strobe();
            t = (cf[3] ? 0 : int'(diode_up)) + (cf[0] ? 0 : int'(diode_right)) - sm(ou)
                + (cf[2] ? 0 : int'(diode_down)) + (cf[1] ? 0 : int'(diode_left)) - sm(od);
            if (cf[5]) t = 2 * t;
            ex = t < 0 ? 0 : (t > 255 ? 255 : t);
            `CHK(proximity_result, 8'(ex))
            `CHK(gesture_active, (ex >= int'(th)))
            `CHK(proximity_valid_flag, 1'b1)
            cmd(1'b1, OFS_PROXIMITY_RESULT, 8'(~ex));
            rd_dev(OFS_PROXIMITY_RESULT, 8'(ex));
            `CHK(proximity_valid_flag, 1'b0)
        end
        cmd(1'b1, OFS_PHOTODIODE_SELECT_CONFIG, 8'h10);
        @(posedge pclk);
        int_event <= 1'b1;
        @(posedge pclk);
        int_event <= 1'b0;
        note(32'h2, 32'h2);
        `CHK(irq, 1'b1)
        strobe();
        `CHK(low_power, 1'b1)
        cmd(1'b0, OFS_PROXIMITY_RESULT, 8'h00);
        strobe();
        `CHK(proximity_valid_flag, 1'b0)
        cmd(1'b1, OFS_CLEAR_INTERRUPT, 8'h00);
        repeat (2) @(negedge pclk);
        `CHK(low_power, 1'b0)
        `CHK(irq, 1'b0)
        note(32'h2, 32'h0);
        strobe();
        `CHK(proximity_valid_flag, 1'b1)
        give_verdict();
    end
endmodule
